// >>> shared/pmrc_pkg.sv
// package: constants, register map and types for the power mode and reset control block
package pmrc_pkg;

  // clock rate, kilohertz, so cycles = milliseconds * rate
  localparam int unsigned CLK_KHZ = 100000;
  // power-on release delay after the supply passes the threshold
  localparam int unsigned POR_DELAY_MS = 128;
  localparam int unsigned POR_DELAY_CYCLES = POR_DELAY_MS * CLK_KHZ;
  // pll relock time after a wake
  localparam int unsigned PLL_LOCK_MS = 1;
  localparam int unsigned PLL_LOCK_CYCLES = PLL_LOCK_MS * CLK_KHZ;
  // extra crystal start time when the oscillator was halted
  localparam int unsigned OSC_START_MS = 150;
  localparam int unsigned OSC_START_CYCLES = OSC_START_MS * CLK_KHZ;

  // register byte offsets
  localparam logic [3:0] OFS_POWER_CONTROL = 4'h0;
  localparam logic [3:0] OFS_PLL_CONTROL = 4'h4;
  localparam logic [3:0] OFS_IRQ_ENABLE = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hc;

  // power_control_reg fields
  localparam int unsigned PC_IDLE_BIT = 0;
  localparam int unsigned PC_SLEEP_BIT = 1;
  localparam int unsigned PC_SERIAL_WAKE_BIT = 2;
  localparam int unsigned PC_EXT0_WAKE_BIT = 3;
  localparam logic [3:0] PC_RESET = 4'h0;
  // pll_control_reg fields
  localparam int unsigned PLL_OSC_HALT_BIT = 3;
  localparam int unsigned PLL_LOCK_BIT = 6;
  localparam logic PLL_OSC_HALT_RESET = 1'b0;
  // irq enable fields: 0 interval counter, 1 serial, 2 ext0, 3 stored only (other requests always enabled), 4 counter run
  localparam int unsigned IE_TIC_BIT = 0;
  localparam int unsigned IE_SERIAL_BIT = 1;
  localparam int unsigned IE_EXT0_BIT = 2;
  localparam int unsigned IE_TIC_RUN_BIT = 4;
  localparam logic [4:0] IE_RESET = 5'h00;

  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // power state, gray along off, count, run, idle, sleep
  typedef enum logic [2:0] {
    PWR_OFF = 3'h0,
    PWR_COUNT = 3'h1,
    PWR_RUN = 3'h3,
    PWR_IDLE = 3'h2,
    PWR_SLEEP = 3'h6
  } pmrc_pwr_e;

  // clock and pin controls handed to the rest of the chip
  typedef struct packed {
    logic core_clk_en;   // pll-derived core clock running
    logic pll_en;        // pll powered
    logic osc_en;        // 32 kHz oscillator powered
    logic periph_clk_en; // peripherals other than the interval counter
    logic tic_clk_en;    // interval_counter clock
    logic cpu_hold;      // core state frozen
    logic port_hold;     // port pins keep their levels
    logic dac_highz;     // converter output three-stated
    logic strobe_force;  // address latch and program_store_strobe forced
    logic strobe_level;  // level they are forced to
  } pmrc_gate_s;

endpackage

// >>> core/pmrc_top.sv
// power mode and reset control: power-on reset, idle and power-down sequencing
//
// Operation
// - hold chip reset while supply below threshold
// - release reset after 128 ms timer expires
// - keep reset held while supply falls away
// - control bit 0 idles, bit 1 powers down
// - idle keeps oscillator, stops core clock only
// - idle freezes core, holds pins, strobes high
// - enabled interrupt or hardware reset ends idle
// - power-down stops pll and core clock
// - halt bit chooses oscillator off in power-down
// - only interval counter may run in power-down
// - power-down holds ports, converter off, strobes low
// - reset pin ends power-down, restores defaults
// - interval counter interrupt wakes from power-down
// - return resumes after the power-down instruction
// - serial wake bit enables serial wake-up
// - ext0 wake bit enables ext0 wake-up
// - pll needs about 1 ms to relock
// - lock status shows in pll control bit 6
// - halted oscillator adds about 150 ms
//
// The implementer's own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/100ps

module pmrc_top
  import pmrc_pkg::*;
#(
  parameter int unsigned POR_CYCLES = POR_DELAY_CYCLES,
  parameter int unsigned LOCK_CYCLES = PLL_LOCK_CYCLES,
  parameter int unsigned OSC_CYCLES = OSC_START_CYCLES
) (
  input wire logic CORE_CLK,
  input wire logic RESET,
  // axi4-lite slave
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [3:0] S_AXI_AWADDR,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  output logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  input wire logic [3:0] S_AXI_ARADDR,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  // supply comparators and reset pin
  input wire logic SUPPLY_ABOVE_POR,
  input wire logic SUPPLY_ABOVE_FLOOR,
  input wire logic EXT_RESET_PIN,
  // interrupt requests: 0 interval counter, 1 serial, 2 ext0, 3 any other
  input wire logic [3:0] IRQ_REQ,
  // outputs
  output logic CHIP_RESET,
  output logic RESUME_PULSE,
  output pmrc_gate_s PWR_GATES
);

  ////////////////
  // helpers

  // count load value, cut to the counter width
  function automatic logic [31:0] to_cnt(input int unsigned v);
    to_cnt = v[31:0];
  endfunction

  // address matches a register offset
  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    hit = (a == ofs);
  endfunction

  ////////////////
  // declarations

  pmrc_pwr_e pwr_reg;        // power state
  pmrc_pwr_e pwr_next;
  logic [31:0] por_cnt_reg;  // power-on release countdown
  logic [31:0] por_cnt_next;
  logic [31:0] lock_cnt_reg; // pll relock countdown
  logic [31:0] lock_cnt_next;
  logic [3:0] pc_reg;        // power_control_reg
  logic osc_halt_reg;        // osc_halt_in_sleep
  logic lock_reg;            // pll lock flag
  logic [4:0] ie_reg;        // interrupt enables and counter run
  logic osc_was_off_reg;     // oscillator was stopped in this sleep
  // bus side
  logic aw_held_reg;         // write address taken
  logic [3:0] aw_addr_reg;
  logic w_held_reg;          // write data taken
  logic [7:0] w_byte_reg;    // low byte of write data
  logic w_lane_reg;          // low byte lane enabled
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic chip_reset_reg;
  logic resume_reg;
  pmrc_gate_s gates_reg;
  pmrc_gate_s gates_next;

  ////////////////
  // decode

  // power-on release and supply loss
  wire supply_lost = !SUPPLY_ABOVE_POR;
  wire por_done = (por_cnt_reg == 32'h0000_0001);
  // block is held in reset by the pin or the supply
  wire hard_reset = EXT_RESET_PIN || supply_lost;
  // enabled requests
  wire [3:0] irq_enabled = IRQ_REQ & {1'b1, ie_reg[IE_EXT0_BIT], ie_reg[IE_SERIAL_BIT],
    ie_reg[IE_TIC_BIT]};
  wire idle_wake = |irq_enabled;
  // power-down wake sources
  wire tic_wake = irq_enabled[0] && ie_reg[IE_TIC_RUN_BIT] && !osc_halt_reg;
  wire serial_wake = irq_enabled[1] && pc_reg[PC_SERIAL_WAKE_BIT];
  wire ext0_wake = irq_enabled[2] && pc_reg[PC_EXT0_WAKE_BIT];
  wire sleep_wake = tic_wake || serial_wake || ext0_wake;
  // leaving idle or sleep by interrupt this cycle
  wire wake_now = ((pwr_reg == PWR_IDLE) && idle_wake) ||
    ((pwr_reg == PWR_SLEEP) && sleep_wake);
  // bus write strobe fires once both halves are held
  wire wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
  wire wr_low = wr_fire && w_lane_reg;
  wire wr_pc = wr_low && hit(aw_addr_reg, OFS_POWER_CONTROL);
  wire wr_pll = wr_low && hit(aw_addr_reg, OFS_PLL_CONTROL);
  wire wr_ie = wr_low && hit(aw_addr_reg, OFS_IRQ_ENABLE);
  wire wr_mapped = hit(aw_addr_reg, OFS_POWER_CONTROL) || hit(aw_addr_reg, OFS_PLL_CONTROL) ||
    hit(aw_addr_reg, OFS_IRQ_ENABLE) || hit(aw_addr_reg, OFS_STATUS);
  wire rd_fire = S_AXI_ARVALID && !rvalid_reg;
  wire rd_mapped = hit(S_AXI_ARADDR, OFS_POWER_CONTROL) || hit(S_AXI_ARADDR, OFS_PLL_CONTROL) ||
    hit(S_AXI_ARADDR, OFS_IRQ_ENABLE) || hit(S_AXI_ARADDR, OFS_STATUS);
  // mode request from a write, sleep beats idle
  wire req_sleep = wr_pc && w_byte_reg[PC_SLEEP_BIT];
  wire req_idle = wr_pc && w_byte_reg[PC_IDLE_BIT] && !w_byte_reg[PC_SLEEP_BIT];
  // pll control read image
  wire [7:0] pll_image = {1'b0, lock_reg, 2'b00, osc_halt_reg, 3'b000};
  // status image: power state and reset
  wire [7:0] stat_image = {4'h0, chip_reset_reg, pwr_reg};
  wire [7:0] rd_byte = hit(S_AXI_ARADDR, OFS_POWER_CONTROL) ? {4'h0, pc_reg} :
    hit(S_AXI_ARADDR, OFS_PLL_CONTROL) ? pll_image :
    hit(S_AXI_ARADDR, OFS_IRQ_ENABLE) ? {3'b000, ie_reg} :
    hit(S_AXI_ARADDR, OFS_STATUS) ? stat_image : 8'h00;

  ////////////////
  // power state machine

  // next power state and power-on countdown
  always_comb begin
    pwr_next = pwr_reg;
    por_cnt_next = por_cnt_reg;
    unique case (pwr_reg)
      PWR_OFF: begin
        // held until supply passes threshold
        if (SUPPLY_ABOVE_POR && !EXT_RESET_PIN) begin
          pwr_next = PWR_COUNT;
          por_cnt_next = to_cnt(POR_CYCLES);
        end
      end
      PWR_COUNT: begin
        if (hard_reset) begin
          pwr_next = PWR_OFF;
        end else if (por_done) begin
          pwr_next = PWR_RUN;
          por_cnt_next = 32'h0000_0000;
        end else begin
          por_cnt_next = por_cnt_reg - 32'h0000_0001;
        end
      end
      PWR_RUN: begin
        if (hard_reset) begin
          pwr_next = PWR_OFF;
        end else if (req_sleep) begin
          pwr_next = PWR_SLEEP;
        end else if (req_idle) begin
          pwr_next = PWR_IDLE;
        end
      end
      PWR_IDLE: begin
        if (hard_reset) begin
          pwr_next = PWR_OFF;
        end else if (idle_wake) begin
          pwr_next = PWR_RUN;
        end
      end
      PWR_SLEEP: begin
        if (hard_reset) begin
          pwr_next = PWR_OFF;
        end else if (sleep_wake) begin
          pwr_next = PWR_RUN;
        end
      end
      default: begin
        // illegal code falls back to reset
        pwr_next = PWR_OFF;
      end
    endcase
  end

  // state and countdown
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      pwr_reg <= PWR_OFF;
      por_cnt_reg <= 32'h0000_0000;
    end else begin
      pwr_reg <= pwr_next;
      por_cnt_reg <= por_cnt_next;
    end
  end

  // chip reset: asserted in off and count, and through supply loss
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      chip_reset_reg <= 1'b1;
    end else begin
      // supply floor is the reset hold on the way down
      chip_reset_reg <= (pwr_next == PWR_OFF) || (pwr_next == PWR_COUNT) ||
        !SUPPLY_ABOVE_FLOOR;
    end
  end

  // one-cycle pulse: core resumes after the mode-entry instruction
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      resume_reg <= 1'b0;
    end else begin
      resume_reg <= wake_now && !hard_reset;
    end
  end

  ////////////////
  // pll lock tracking

  // relock countdown after reset or a power-down wake
  always_comb begin
    lock_cnt_next = lock_cnt_reg;
    if (hard_reset || pwr_reg == PWR_OFF || pwr_reg == PWR_COUNT) begin
      lock_cnt_next = to_cnt(LOCK_CYCLES);
    end else if (pwr_reg == PWR_SLEEP && sleep_wake) begin
      // crystal restart adds to the pll lock time
      lock_cnt_next = osc_was_off_reg ? to_cnt(LOCK_CYCLES + OSC_CYCLES) :
        to_cnt(LOCK_CYCLES);
    end else if (lock_cnt_reg != 32'h0000_0000) begin
      lock_cnt_next = lock_cnt_reg - 32'h0000_0001;
    end
  end

  // lock flag and oscillator history
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      lock_cnt_reg <= 32'h0000_0000;
      lock_reg <= 1'b0;
      osc_was_off_reg <= 1'b0;
    end else begin
      lock_cnt_reg <= lock_cnt_next;
      // pll stopped in sleep loses lock
      if (pwr_reg == PWR_SLEEP || lock_cnt_next != 32'h0000_0000) begin
        lock_reg <= 1'b0;
      end else begin
        lock_reg <= 1'b1;
      end
      // remember a halted crystal through the sleep
      if (pwr_reg == PWR_SLEEP) begin
        osc_was_off_reg <= osc_halt_reg;
      end else if (pwr_reg == PWR_RUN) begin
        osc_was_off_reg <= 1'b0;
      end
    end
  end

  ////////////////
  // clock and pin gating

  // gate pattern for the next state
  always_comb begin
    gates_next = '0;
    gates_next.osc_en = 1'b1;
    gates_next.pll_en = 1'b1;
    gates_next.core_clk_en = 1'b1;
    gates_next.periph_clk_en = 1'b1;
    gates_next.tic_clk_en = ie_reg[IE_TIC_RUN_BIT];
    unique case (pwr_next)
      PWR_IDLE: begin
        // oscillator and peripherals keep going
        gates_next.core_clk_en = 1'b0;
        gates_next.cpu_hold = 1'b1;
        gates_next.port_hold = 1'b1;
        gates_next.strobe_force = 1'b1;
        gates_next.strobe_level = 1'b1;
      end
      PWR_SLEEP: begin
        gates_next.pll_en = 1'b0;
        gates_next.core_clk_en = 1'b0;
        gates_next.osc_en = !osc_halt_reg;
        gates_next.periph_clk_en = 1'b0;
        gates_next.tic_clk_en = ie_reg[IE_TIC_RUN_BIT] && !osc_halt_reg;
        gates_next.cpu_hold = 1'b1;
        gates_next.port_hold = 1'b1;
        gates_next.dac_highz = 1'b1;
        gates_next.strobe_force = 1'b1;
        gates_next.strobe_level = 1'b0;
      end
      PWR_OFF, PWR_COUNT: begin
        // chip in reset, clocks kept so the core can start
        gates_next.core_clk_en = 1'b1;
      end
      default: begin
        // run: every clock on but the interval counter's, which follows its run bit
        gates_next.core_clk_en = 1'b1;
      end
    endcase
  end

  // registered gate outputs
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      gates_reg <= '0;
    end else begin
      gates_reg <= gates_next;
    end
  end

  ////////////////
  // software registers

  // power control: mode bits clear on wake or reset
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      pc_reg <= PC_RESET;
    end else if (hard_reset) begin
      pc_reg <= PC_RESET;
    end else if (wr_pc) begin
      pc_reg <= w_byte_reg[3:0];
      // sleep takes priority, idle bit not kept with it
      if (w_byte_reg[PC_SLEEP_BIT]) begin
        pc_reg[PC_IDLE_BIT] <= 1'b0;
      end
    end else if (pwr_next == PWR_RUN && pwr_reg != PWR_RUN) begin
      // wake keeps the wake enables, drops the mode bits
      pc_reg[PC_IDLE_BIT] <= 1'b0;
      pc_reg[PC_SLEEP_BIT] <= 1'b0;
    end
  end

  // pll control and interrupt enables
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      osc_halt_reg <= PLL_OSC_HALT_RESET;
      ie_reg <= IE_RESET;
    end else if (hard_reset) begin
      osc_halt_reg <= PLL_OSC_HALT_RESET;
      ie_reg <= IE_RESET;
    end else begin
      if (wr_pll) begin
        osc_halt_reg <= w_byte_reg[PLL_OSC_HALT_BIT];
      end
      if (wr_ie) begin
        ie_reg <= w_byte_reg[4:0];
      end
    end
  end

  ////////////////
  // axi4-lite write channel

  // address and data taken in either order
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_held_reg <= 1'b0;
      w_byte_reg <= 8'h00;
      w_lane_reg <= 1'b0;
    end else begin
      if (S_AXI_AWVALID && !aw_held_reg) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= S_AXI_AWADDR;
      end else if (wr_fire) begin
        aw_held_reg <= 1'b0;
      end
      if (S_AXI_WVALID && !w_held_reg) begin
        w_held_reg <= 1'b1;
        w_byte_reg <= S_AXI_WDATA[7:0];
        w_lane_reg <= S_AXI_WSTRB[0];
      end else if (wr_fire) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // write response
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      bvalid_reg <= 1'b0;
    end
  end

  ////////////////
  // axi4-lite read channel

  // read data registered one cycle after address
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= {24'h00_0000, rd_byte};
      rresp_reg <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      rvalid_reg <= 1'b0;
    end
  end

  ////////////////
  // outputs

  assign S_AXI_AWREADY = !aw_held_reg;
  assign S_AXI_WREADY = !w_held_reg;
  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP = bresp_reg;
  assign S_AXI_ARREADY = !rvalid_reg;
  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RDATA = rdata_reg;
  assign S_AXI_RRESP = rresp_reg;
  assign CHIP_RESET = chip_reset_reg;
  assign RESUME_PULSE = resume_reg;
  assign PWR_GATES = gates_reg;

endmodule

// >>> bench/pmrc_top_sva.sv
// checker: port-level assertions for the power mode and reset control block
`timescale 1ns/100ps

module pmrc_checker
  import pmrc_pkg::*;
#(
  parameter int unsigned POR_CYCLES = 20
) (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic SUPPLY_ABOVE_POR,
  input wire logic SUPPLY_ABOVE_FLOOR,
  input wire logic EXT_RESET_PIN,
  input wire logic [3:0] IRQ_REQ,
  input wire logic CHIP_RESET,
  input wire logic RESUME_PULSE,
  input wire pmrc_gate_s PWR_GATES
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);

  ////////////////////////////////////////////////////////////////////////////////
  // cycles of good supply seen while chip reset is still held
  logic [31:0] good_cnt_reg;
  logic [31:0] good_cnt_next;
  wire good_cond = CHIP_RESET && SUPPLY_ABOVE_POR && !EXT_RESET_PIN;
  assign good_cnt_next = good_cond ? good_cnt_reg + 32'h1 : 32'h0;
  // counter restarts on any interruption
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      good_cnt_reg <= 32'h0;
    end else begin
      good_cnt_reg <= good_cnt_next;
    end
  end
  // mode patterns decoded from the gate vector
  wire idle_seen = !CHIP_RESET && PWR_GATES.pll_en && !PWR_GATES.core_clk_en;
  wire sleep_seen = !CHIP_RESET && !PWR_GATES.pll_en && PWR_GATES.strobe_force;
  wire quiet = (IRQ_REQ == 4'h0) && !EXT_RESET_PIN && SUPPLY_ABOVE_FLOOR && SUPPLY_ABOVE_POR;

  ////////////////////////////////////////////////////////////////////////////////
  AST_LOW_SUPPLY_HOLDS: assert property (
    !SUPPLY_ABOVE_POR |=> CHIP_RESET) else $error("reset not held under threshold");
  AST_RELEASE_DELAY: assert property (
    $fell(CHIP_RESET) |-> good_cnt_reg >= POR_CYCLES) else $error("reset released early");
  AST_FLOOR_HOLDS: assert property (
    !SUPPLY_ABOVE_FLOOR |=> CHIP_RESET) else $error("reset not held under floor");
  AST_PIN_HOLDS: assert property (
    EXT_RESET_PIN |=> CHIP_RESET) else $error("reset pin ignored");
  AST_IDLE_GATES: assert property (
    idle_seen |-> PWR_GATES.osc_en && PWR_GATES.periph_clk_en && PWR_GATES.cpu_hold
      && PWR_GATES.port_hold && PWR_GATES.strobe_level && !PWR_GATES.dac_highz)
    else $error("idle gate pattern wrong");
  AST_SLEEP_GATES: assert property (
    sleep_seen |-> !PWR_GATES.core_clk_en && !PWR_GATES.periph_clk_en
      && PWR_GATES.port_hold && PWR_GATES.dac_highz && !PWR_GATES.strobe_level)
    else $error("sleep gate pattern wrong");
  AST_WAKE_CAUSE: assert property (
    $rose(RESUME_PULSE) |-> ($past(IRQ_REQ) != 4'h0) && PWR_GATES.core_clk_en)
    else $error("resume without request");
  AST_PULSE_SINGLE: assert property (
    RESUME_PULSE |=> !RESUME_PULSE) else $error("resume pulse too long");
  AST_SLEEP_STAYS: assert property (
    sleep_seen && quiet |=> sleep_seen) else $error("sleep left without cause");
endmodule

bind pmrc_top pmrc_checker #(.POR_CYCLES(POR_CYCLES)) pmrc_checker_inst (
  .CORE_CLK(CORE_CLK),
  .RESET(RESET),
  .SUPPLY_ABOVE_POR(SUPPLY_ABOVE_POR),
  .SUPPLY_ABOVE_FLOOR(SUPPLY_ABOVE_FLOOR),
  .EXT_RESET_PIN(EXT_RESET_PIN),
  .IRQ_REQ(IRQ_REQ),
  .CHIP_RESET(CHIP_RESET),
  .RESUME_PULSE(RESUME_PULSE),
  .PWR_GATES(PWR_GATES)
);

// >>> bench/pmrc_core_model.sv
// model: core and wake sources, requests pending until the core resumes
`timescale 1ns/100ps

module pmrc_core_model
  import pmrc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] raise,
  input wire logic resume,
  input wire logic chip_rst,
  output logic [3:0] irq_req
);
  logic [3:0] irq_req_reg; // pending request levels
  logic [3:0] irq_req_next;
  // handler return drops what was pending, new raises still land
  assign irq_req_next = (resume || chip_rst) ? raise : (irq_req_reg | raise);
  // level requests, held until serviced
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_req_reg <= 4'h0;
    end else begin
      irq_req_reg <= irq_req_next;
    end
  end
  assign irq_req = irq_req_reg;
endmodule

// >>> bench/test_power_mode_and_reset_control.sv
// testbench: power-on, register, mode and wake sequences
`timescale 1ns/100ps

module test_power_mode_and_reset_control
  import pmrc_pkg::*;
;
  localparam int POR = 20; // shortened counts
  localparam int LOCK = 10;
  localparam int OSC = 30;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic por_ok = 1'b0;
  logic floor_ok = 1'b1;
  logic ext_rst = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0, raise = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, chip_reset, resume_pulse;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [3:0] irq_req;
  pmrc_gate_s gates;
  int error_cnt = 0, num_checks = 0, cyc = 0;

  always #5 clk = ~clk;

  pmrc_top #(.POR_CYCLES(POR), .LOCK_CYCLES(LOCK), .OSC_CYCLES(OSC)) pmrc_top_inst (
    .CORE_CLK(clk), .RESET(rst),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_AWADDR(awaddr),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_BRESP(bresp),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_ARADDR(araddr),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .SUPPLY_ABOVE_POR(por_ok), .SUPPLY_ABOVE_FLOOR(floor_ok), .EXT_RESET_PIN(ext_rst),
    .IRQ_REQ(irq_req), .CHIP_RESET(chip_reset), .RESUME_PULSE(resume_pulse), .PWR_GATES(gates)
  );

  pmrc_core_model pmrc_core_model_inst (
    .clk(clk), .rst(rst), .raise(raise), .resume(resume_pulse),
    .chip_rst(chip_reset), .irq_req(irq_req)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // verdict and stop
  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // write: both halves offered, each dropped once taken
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    check("write resp", bresp, RESP_OKAY);
    bready <= 1'b0;
    @(posedge clk);
  endtask

  // read: address held until taken, data taken with rvalid
  task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask

  // read, mask and compare
  task automatic rd_check(input string what, input logic [3:0] a, input logic [31:0] m,
      input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    check(what, d & m, e);
    check("read resp", r, RESP_OKAY);
  endtask

  // cycles until chip reset drops, bounded
  task automatic wait_run(output int n);
    n = 0;
    while (chip_reset !== 1'b0 && n < 400) begin
      @(posedge clk);
      n++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // supply ramp and release delay
  task automatic t_power_on();
    int n;
    repeat (8) @(posedge clk);
    check("reset low supply", chip_reset, 1'b1);
    rd_check("status off", OFS_STATUS, 32'hff, 32'h8);
    por_ok <= 1'b1;
    wait_run(n);
    check("por delay", n >= POR + 1 && n <= POR + 3, 1'b1);
    rd_check("status run", OFS_STATUS, 32'hff, 32'h3);
  endtask

  // strobes, read-only places, lock bit
  task automatic t_regs();
    axi_write(OFS_IRQ_ENABLE, 32'h17, 4'hf);
    axi_write(OFS_IRQ_ENABLE, 32'h00, 4'h0);
    rd_check("irq enable", OFS_IRQ_ENABLE, 32'hffffffff, 32'h17);
    axi_write(OFS_PLL_CONTROL, 32'hff, 4'h1);
    rd_check("osc halt bit", OFS_PLL_CONTROL, 32'hffffff08, 32'h8);
    rd_check("lock bit", OFS_PLL_CONTROL, 32'h40, 32'h40);
    axi_write(OFS_STATUS, 32'h0, 4'hf);
    rd_check("status read only", OFS_STATUS, 32'hff, 32'h3);
  endtask

  // enter a mode, refuse a disabled request, wake, wait for lock
  task automatic mode_wake(input logic [31:0] pll, input logic [31:0] ie, input logic [31:0] pc,
      input logic [31:0] ep, input logic [3:0] dud, input logic [3:0] wake,
      input logic [9:0] eg, input logic [9:0] m, input int lock_wait);
    int n;
    int t0;
    logic [31:0] d;
    logic [1:0] r;
    axi_write(OFS_PLL_CONTROL, pll, 4'h1);
    axi_write(OFS_IRQ_ENABLE, ie, 4'h1);
    axi_write(OFS_POWER_CONTROL, pc, 4'h1);
    check("mode gates", gates & m, eg);
    rd_check("stored mode", OFS_POWER_CONTROL, 32'hf, ep);
    raise <= dud;
    @(posedge clk);
    raise <= 4'h0;
    repeat (5) @(posedge clk);
    check("no wake", gates & m, eg);
    raise <= wake;
    @(posedge clk);
    raise <= 4'h0;
    n = 0;
    while (resume_pulse !== 1'b1 && n < 10) begin
      @(posedge clk);
      n++;
    end
    check("woke", resume_pulse, 1'b1);
    check("run gates", gates & 10'h3de, 10'h3c0);
    t0 = cyc;
    d = 32'h0;
    while (d[6] !== 1'b1 && cyc - t0 < 100) begin
      axi_read(OFS_PLL_CONTROL, d, r);
    end
    check("lock time", cyc - t0 >= lock_wait - 2 && cyc - t0 <= lock_wait + 10, 1'b1);
    rd_check("mode bits cleared", OFS_POWER_CONTROL, 32'hf, ep & 32'hc);
  endtask

  // idle and the three power-down wake paths
  task automatic t_modes();
    mode_wake(0, 0, 1, 1, 4'h1, 4'h8, 10'h1db, 10'h3df, 0);
    mode_wake(8, 4, 10, 10, 4'h2, 4'h4, 10'h00e, 10'h3cf, LOCK + OSC);
    mode_wake(0, 2, 6, 6, 4'h4, 4'h2, 10'h08e, 10'h3cf, LOCK);
    mode_wake(0, 17, 3, 2, 4'h2, 4'h1, 10'h0ae, 10'h3ef, LOCK);
  endtask

  // pin reset out of power-down, then a supply dip
  task automatic t_resets();
    int n;
    axi_write(OFS_PLL_CONTROL, 32'h8, 4'h1);
    axi_write(OFS_IRQ_ENABLE, 32'h4, 4'h1);
    axi_write(OFS_POWER_CONTROL, 32'h2, 4'h1);
    ext_rst <= 1'b1;
    repeat (3) @(posedge clk);
    check("pin reset", chip_reset, 1'b1);
    rd_check("control default", OFS_POWER_CONTROL, 32'hf, 32'h0);
    rd_check("enable default", OFS_IRQ_ENABLE, 32'h1f, 32'h0);
    rd_check("halt default", OFS_PLL_CONTROL, 32'h8, 32'h0);
    ext_rst <= 1'b0;
    wait_run(n);
    check("run after pin", gates & 10'h3de, 10'h3c0);
    por_ok <= 1'b0;
    repeat (3) @(posedge clk);
    check("supply falling", chip_reset, 1'b1);
    floor_ok <= 1'b0;
    repeat (3) @(posedge clk);
    check("below floor", chip_reset, 1'b1);
    por_ok <= 1'b1;
    floor_ok <= 1'b1;
    wait_run(n);
    check("repower delay", n >= POR + 1 && n <= POR + 3, 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_power_on();
    t_regs();
    t_modes();
    t_resets();
    end_sim();
  end

  // cycle count and hang limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      end_sim();
    end
  end
endmodule
